// [shared/scm_pkg.sv]
// shared constants, types and helpers for the system clock and mode block
package scm_pkg;

  // ****************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam int        ADDR_W       = 4;
  localparam logic [3:0] OFF_SYSCLK  = 4'h0;
  localparam logic [3:0] OFF_FASTOSC = 4'h4;
  localparam logic [3:0] OFF_STATUS  = 4'h8;

  // system_clock_control fields
  localparam int SEL_LSB       = 5;
  localparam int SEL_W         = 3;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;

  // fast_oscillator_control fields
  localparam int FREQ_LSB   = 2;
  localparam int FREQ_W     = 2;
  localparam int STABLE_BIT = 1;
  localparam int ENABLE_BIT = 0;

  // status fields
  localparam int PWRDN_BIT  = 0;
  localparam int EXPIRY_BIT = 1;
  localparam int MODE_LSB   = 2;
  localparam int ACTSLW_BIT = 5;

  // reset values
  localparam logic [2:0] SEL_RST       = 3'h0;
  localparam logic       KEEP_RST      = 1'b0;
  localparam logic [1:0] FREQ_RST      = 2'h0;
  localparam logic       FOSC_EN_RST   = 1'b1;
  localparam logic       STABLE_RST    = 1'b0;

  // clock selection codes and prescaler depth
  localparam logic [2:0] SEL_SLOW   = 3'h7;
  localparam int         DIV_STAGES = 6;
  localparam logic [1:0] FREQ_4MHZ  = 2'h0;
  localparam logic [1:0] FREQ_ALIAS = 2'h3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_RUN   = 3'b000,
    MODE_SLEEP = 3'b001,
    MODE_IDLE0 = 3'b010,
    MODE_IDLE1 = 3'b011,
    MODE_IDLE2 = 3'b100
  } scm_mode_t;

  typedef struct packed {
    logic cpu_run;
    logic fast_osc_on;
    logic slow_clk_on;
    logic slow_rc_on;
  } scm_clk_en_t;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic scm_mode_t scm_halt_mode(input logic fast_keep,
                                              input logic slow_keep);
    case ({fast_keep, slow_keep})
      2'b00:   scm_halt_mode = MODE_SLEEP;
      2'b01:   scm_halt_mode = MODE_IDLE0;
      2'b11:   scm_halt_mode = MODE_IDLE1;
      default: scm_halt_mode = MODE_IDLE2;
    endcase
  endfunction

  function automatic logic [1:0] scm_freq_map(input logic [1:0] code);
    scm_freq_map = (code == FREQ_ALIAS) ? FREQ_4MHZ : code;
  endfunction

endpackage

// [logic/scm_prescaler.sv]
// binary prescaler, counting only while run is high, giving fast clock divide ticks
`timescale 1ns/1ps

module scm_prescaler #(
  parameter int STAGES = scm_pkg::DIV_STAGES
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  // control and ticks
  input  wire logic              run,
  output logic [STAGES:0]        div_tick
);

  logic [STAGES-1:0] cnt_q;
  logic              ones_so_far;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (run) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // tick n marks the last fast cycle of a 2^n period
  // running and of the low bits; avoids a variable-width part-select
  always_comb begin
    ones_so_far = run;
    div_tick[0] = run;
    for (int n = 1; n <= STAGES; n++) begin
      ones_so_far = ones_so_far && cnt_q[n-1];
      div_tick[n] = ones_so_far;
    end
  end

endmodule // scm_prescaler

// [logic/scm_clk_switch.sv]
// glitch-free system clock source switch on tick boundaries
`timescale 1ns/1ps

module scm_clk_switch #(
  parameter int STAGES = scm_pkg::DIV_STAGES
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  // selection
  input  wire logic [2:0]        req_sel,
  input  wire logic              slow_ok,
  input  wire logic              fast_ok,
  input  wire logic              run,
  // tick sources
  input  wire logic [STAGES:0]   div_tick,
  input  wire logic              slow_tick,
  // result
  output logic [2:0]             act_sel_q,
  output logic                   sys_tick_q
);

  function automatic logic tick_of(input logic [2:0] sel);
    tick_of = (sel == scm_pkg::SEL_SLOW) ? slow_tick : div_tick[sel];
  endfunction

  logic src_tick;
  logic tgt_ok;
  logic swap;

  // swap where the old period ends (or run is low) and, for a fast target, the new one begins
  always_comb begin
    src_tick = tick_of(act_sel_q);
    tgt_ok   = (req_sel == scm_pkg::SEL_SLOW) ? slow_ok : fast_ok;
    swap     = (req_sel != act_sel_q) && tgt_ok && (src_tick || !run) &&
               ((req_sel == scm_pkg::SEL_SLOW) || tick_of(req_sel));
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_sel_q <= scm_pkg::SEL_RST;
    end else if (swap) begin
      act_sel_q <= req_sel;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_tick_q <= 1'b0;
    end else begin
      sys_tick_q <= run && src_tick;
    end
  end

  a_slow_needs_ready: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    $rose(act_sel_q == scm_pkg::SEL_SLOW) |-> $past(slow_ok))
    else $error("slow source taken before slow oscillator ready");

  a_fast_needs_stable: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    $fell(act_sel_q == scm_pkg::SEL_SLOW) |-> $past(fast_ok))
    else $error("fast source taken before fast oscillator stable");

endmodule // scm_clk_switch

// [logic/scm_clk_ctrl.sv]
// system clock selection, fast oscillator control and power modes
`timescale 1ns/1ps

// What this block does
// - select fast, fast divided, or slow clock
// - slow mode runs from slow rc oscillator
// - halt with both keeps low enters sleep
// - fast keep 0, slow keep 1 enters idle0
// - both keeps high enters idle1
// - fast keep 1, slow keep 0 enters idle2
// - watchdog enabled keeps slow rc running halted
// - fast keep decides fast oscillator while halted
// - frequency codes 4/8/12 MHz; code 11 4MHz
// - enabling fast oscillator clears stable flag
// - switch to slow waits for slow ready
// - return to fast waits for stable oscillator
// - halt keeps memory, registers and ports
// - halt sets power-down, clears watchdog expiry
// - halt clears the watchdog counter
// - unimplemented clock control bits read zero
module scm_clk_ctrl #(
  parameter int DIV_STAGES = scm_pkg::DIV_STAGES
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // avalon-mm slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // cpu and watchdog side
  input  wire logic                 halt_req,
  input  wire logic                 wake_req,
  input  wire logic                 wdt_enable,
  input  wire logic                 wdt_timeout,
  // oscillator side
  input  wire logic                 fast_osc_ready,
  input  wire logic                 slow_osc_ready,
  input  wire logic                 slow_osc_tick,
  // clock controls
  output logic                      sys_clk_tick,
  output scm_pkg::scm_clk_en_t      clk_en,
  output logic [1:0]                fast_osc_freq_sel,
  output logic                      wdt_clear
);

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic        wait_q;
  logic [31:0] readdata_q;
  logic        wr_hit;
  logic        wr_sysclk;
  logic        wr_fastosc;
  logic        wr_status;
  logic [31:0] rd_data;

  // software registers and block state
  logic [2:0]          sysclk_select_q;
  logic                fast_osc_idle_keep_q;
  logic                slow_osc_idle_keep_q;
  logic [1:0]          fast_osc_freq_sel_q;
  logic                fast_osc_enable_q;
  logic                fast_osc_stable_flag_q;
  logic                power_down_flag_q;
  logic                watchdog_expiry_flag_q;
  scm_pkg::scm_mode_t  mode_q;
  scm_pkg::scm_mode_t  mode_d;
  scm_pkg::scm_clk_en_t clk_en_q;
  scm_pkg::scm_clk_en_t clk_en_d;
  logic [1:0]          freq_out_q;
  logic                wdt_clear_q;
  logic                halt_go;
  logic                en_rise;
  logic [2:0]          act_sel;
  logic                act_slow;
  logic                sys_run;
  logic                sys_tick;
  logic [DIV_STAGES:0] div_tick;

  // one wait cycle on every access, then one cycle with wait low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  always_comb begin
    wr_hit     = avs_write && !wait_q && avs_byteenable[0];
    wr_sysclk  = wr_hit && (avs_address == scm_pkg::OFF_SYSCLK);
    wr_fastosc = wr_hit && (avs_address == scm_pkg::OFF_FASTOSC);
    wr_status  = wr_hit && (avs_address == scm_pkg::OFF_STATUS);
  end

  // unmapped addresses read zero and ignore writes
  always_comb begin
    rd_data = '0;
    if (avs_address == scm_pkg::OFF_SYSCLK) begin
      rd_data[scm_pkg::SEL_LSB +: scm_pkg::SEL_W] = sysclk_select_q;
      rd_data[scm_pkg::FAST_KEEP_BIT] = fast_osc_idle_keep_q;
      rd_data[scm_pkg::SLOW_KEEP_BIT] = slow_osc_idle_keep_q;
    end else if (avs_address == scm_pkg::OFF_FASTOSC) begin
      rd_data[scm_pkg::FREQ_LSB +: scm_pkg::FREQ_W] = fast_osc_freq_sel_q;
      rd_data[scm_pkg::STABLE_BIT] = fast_osc_stable_flag_q;
      rd_data[scm_pkg::ENABLE_BIT] = fast_osc_enable_q;
    end else if (avs_address == scm_pkg::OFF_STATUS) begin
      rd_data[scm_pkg::PWRDN_BIT]  = power_down_flag_q;
      rd_data[scm_pkg::EXPIRY_BIT] = watchdog_expiry_flag_q;
      rd_data[scm_pkg::MODE_LSB +: 3] = mode_q;
      rd_data[scm_pkg::ACTSLW_BIT] = act_slow;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata_q <= '0;
    end else if (avs_read && wait_q) begin
      readdata_q <= rd_data;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sysclk_select_q      <= scm_pkg::SEL_RST;
      fast_osc_idle_keep_q <= scm_pkg::KEEP_RST;
      slow_osc_idle_keep_q <= scm_pkg::KEEP_RST;
    end else if (wr_sysclk) begin
      sysclk_select_q <= avs_writedata[scm_pkg::SEL_LSB +: scm_pkg::SEL_W];
      fast_osc_idle_keep_q <= avs_writedata[scm_pkg::FAST_KEEP_BIT];
      slow_osc_idle_keep_q <= avs_writedata[scm_pkg::SLOW_KEEP_BIT];
    end
  end

  always_comb begin
    en_rise = wr_fastosc && avs_writedata[scm_pkg::ENABLE_BIT] &&
              !fast_osc_enable_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_osc_freq_sel_q <= scm_pkg::FREQ_RST;
      fast_osc_enable_q   <= scm_pkg::FOSC_EN_RST;
    end else if (wr_fastosc) begin
      fast_osc_freq_sel_q <=
        avs_writedata[scm_pkg::FREQ_LSB +: scm_pkg::FREQ_W];
      fast_osc_enable_q <= avs_writedata[scm_pkg::ENABLE_BIT];
    end
  end

  // flag drops whenever the oscillator is restarted or stopped
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_osc_stable_flag_q <= scm_pkg::STABLE_RST;
    end else if (en_rise) begin
      fast_osc_stable_flag_q <= 1'b0;
    end else begin
      fast_osc_stable_flag_q <= clk_en_q.fast_osc_on && fast_osc_ready;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      freq_out_q <= scm_pkg::FREQ_4MHZ;
    end else begin
      freq_out_q <= scm_pkg::scm_freq_map(fast_osc_freq_sel_q);
    end
  end

  // ****************************************************************
  // power mode sequencing
  // ****************************************************************
  always_comb begin
    mode_d  = mode_q;
    halt_go = 1'b0;
    case (mode_q)
      scm_pkg::MODE_RUN: begin
        if (halt_req) begin
          mode_d  = scm_pkg::scm_halt_mode(fast_osc_idle_keep_q,
                                           slow_osc_idle_keep_q);
          halt_go = 1'b1;
        end
      end
      default: begin
        if (wake_req || wdt_timeout) begin
          mode_d = scm_pkg::MODE_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= scm_pkg::MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // status flags: a hardware set beats a software clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_down_flag_q <= 1'b0;
    end else if (halt_go) begin
      power_down_flag_q <= 1'b1;
    end else if (wr_status && avs_writedata[scm_pkg::PWRDN_BIT]) begin
      power_down_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_expiry_flag_q <= 1'b0;
    end else if (halt_go) begin
      watchdog_expiry_flag_q <= 1'b0;
    end else if (wdt_timeout) begin
      watchdog_expiry_flag_q <= 1'b1;
    end else if (wr_status && avs_writedata[scm_pkg::EXPIRY_BIT]) begin
      watchdog_expiry_flag_q <= 1'b0;
    end
  end

  // counter restarts on every halt, whether or not the watchdog is enabled
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wdt_clear_q <= 1'b0;
    end else begin
      wdt_clear_q <= halt_go;
    end
  end

  // ****************************************************************
  // clock enables
  // ****************************************************************
  always_comb begin
    act_slow = (act_sel == scm_pkg::SEL_SLOW);
    clk_en_d.cpu_run    = (mode_d == scm_pkg::MODE_RUN);
    clk_en_d.slow_rc_on = !((mode_d == scm_pkg::MODE_SLEEP) &&
                            !wdt_enable);
    case (mode_d)
      scm_pkg::MODE_RUN: begin
        // a selected fast source keeps the oscillator alive
        clk_en_d.fast_osc_on = fast_osc_enable_q || !act_slow;
        clk_en_d.slow_clk_on = 1'b1;
      end
      scm_pkg::MODE_IDLE0: begin
        clk_en_d.fast_osc_on = 1'b0;
        clk_en_d.slow_clk_on = 1'b1;
      end
      scm_pkg::MODE_IDLE1: begin
        clk_en_d.fast_osc_on = 1'b1;
        clk_en_d.slow_clk_on = 1'b1;
      end
      scm_pkg::MODE_IDLE2: begin
        clk_en_d.fast_osc_on = 1'b1;
        clk_en_d.slow_clk_on = act_slow;
      end
      default: begin
        clk_en_d.fast_osc_on = 1'b0;
        clk_en_d.slow_clk_on = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_en_q <= '{cpu_run: 1'b1, fast_osc_on: 1'b1,
                    slow_clk_on: 1'b1, slow_rc_on: 1'b1};
    end else begin
      clk_en_q <= clk_en_d;
    end
  end

  // system clock keeps ticking only where its source stays alive
  always_comb begin
    case (mode_q)
      scm_pkg::MODE_RUN:   sys_run = 1'b1;
      scm_pkg::MODE_IDLE1: sys_run = 1'b1;
      scm_pkg::MODE_IDLE0: sys_run = act_slow;
      scm_pkg::MODE_IDLE2: sys_run = !act_slow;
      default:             sys_run = 1'b0;
    endcase
  end

  // ****************************************************************
  // prescaler and source switch
  // ****************************************************************
  scm_prescaler #(
    .STAGES (DIV_STAGES)
  ) u_prescaler (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .run      (clk_en_q.fast_osc_on),
    .div_tick (div_tick)
  );

  scm_clk_switch #(
    .STAGES (DIV_STAGES)
  ) u_switch (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .req_sel    (sysclk_select_q),
    .slow_ok    (slow_osc_ready && clk_en_q.slow_rc_on),
    .fast_ok    (fast_osc_stable_flag_q),
    .run        (sys_run),
    .div_tick   (div_tick),
    .slow_tick  (slow_osc_tick && clk_en_q.slow_rc_on),
    .act_sel_q  (act_sel),
    .sys_tick_q (sys_tick)
  );

  assign avs_readdata      = readdata_q;
  assign avs_waitrequest   = wait_q;
  assign sys_clk_tick      = sys_tick;
  assign clk_en            = clk_en_q;
  assign fast_osc_freq_sel = freq_out_q;
  assign wdt_clear         = wdt_clear_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_sleep_entry: assert property (
    (mode_q == scm_pkg::MODE_RUN && halt_req && !fast_osc_idle_keep_q &&
     !slow_osc_idle_keep_q) |=> (mode_q == scm_pkg::MODE_SLEEP) &&
     !clk_en.cpu_run && !clk_en.fast_osc_on && !clk_en.slow_clk_on)
    else $error("sleep not entered");

  a_idle0_entry: assert property (
    (mode_q == scm_pkg::MODE_RUN && halt_req && !fast_osc_idle_keep_q &&
     slow_osc_idle_keep_q) |=> (mode_q == scm_pkg::MODE_IDLE0) &&
     !clk_en.fast_osc_on && clk_en.slow_clk_on)
    else $error("idle0 not entered");

  a_idle1_entry: assert property (
    (mode_q == scm_pkg::MODE_RUN && halt_req && fast_osc_idle_keep_q &&
     slow_osc_idle_keep_q) |=> (mode_q == scm_pkg::MODE_IDLE1) &&
     clk_en.fast_osc_on && clk_en.slow_clk_on && !clk_en.cpu_run)
    else $error("idle1 not entered");

  a_idle2_entry: assert property (
    (mode_q == scm_pkg::MODE_RUN && halt_req && fast_osc_idle_keep_q &&
     !slow_osc_idle_keep_q) |=> (mode_q == scm_pkg::MODE_IDLE2) &&
     clk_en.fast_osc_on && !clk_en.cpu_run)
    else $error("idle2 not entered");

  a_wdt_keeps_rc: assert property (
    (mode_q == scm_pkg::MODE_SLEEP && $past(wdt_enable)) |->
     clk_en.slow_rc_on)
    else $error("slow rc stopped with watchdog enabled");

  a_stable_clear: assert property (
    en_rise |=> !fast_osc_stable_flag_q)
    else $error("stable flag not cleared on enable");

  a_freq_alias: assert property (
    ($past(fast_osc_freq_sel_q) == scm_pkg::FREQ_ALIAS) |->
     (fast_osc_freq_sel == scm_pkg::FREQ_4MHZ))
    else $error("frequency code 11 not mapped to 4MHz");

  a_halt_flags: assert property (
    halt_go |=> power_down_flag_q && !watchdog_expiry_flag_q &&
     wdt_clear ##1 !wdt_clear)
    else $error("halt side effects missing");

  a_reserved_zero: assert property (
    (avs_read && !wait_q && avs_address == scm_pkg::OFF_SYSCLK) |->
     (avs_readdata[4:2] == 3'h0))
    else $error("unimplemented bits read nonzero");

endmodule // scm_clk_ctrl

// [bench/test_scm_clk_ctrl.sv]
// self-checking bench for the system clock and power mode block
`timescale 1ns/1ps

module test_scm_clk_ctrl;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int SLOW_PER = 20;
  typedef struct {
    logic [2:0] sel;
    logic [1:0] freq;
    int         per;
    logic [1:0] fsel;
  } scm_tb_row_t;

  logic                 sys_clk = 1'b0;
  logic                 reset_n;
  logic [3:0]           avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [31:0]          avs_writedata;
  logic [3:0]           avs_byteenable;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  logic                 halt_req;
  logic                 wake_req;
  logic                 wdt_enable;
  logic                 wdt_timeout;
  logic                 fast_osc_ready;
  logic                 slow_osc_ready;
  logic                 slow_osc_tick = 1'b0;
  logic                 sys_clk_tick;
  scm_pkg::scm_clk_en_t clk_en;
  logic [1:0]           fast_osc_freq_sel;
  logic                 wdt_clear;
  scm_tb_row_t          rows [8];
  int                   n_errors;
  int                   checks_done;
  int                   slow_cnt = 0;
  int                   p;
  logic [31:0]          rd;
  logic [1:0]           kk;
  logic [3:0]           e;
  logic [2:0]           m;

  scm_clk_ctrl #(.DIV_STAGES(6)) dut (
    .sys_clk           (sys_clk),
    .reset_n           (reset_n),
    .avs_address       (avs_address),
    .avs_read          (avs_read),
    .avs_write         (avs_write),
    .avs_writedata     (avs_writedata),
    .avs_byteenable    (avs_byteenable),
    .avs_readdata      (avs_readdata),
    .avs_waitrequest   (avs_waitrequest),
    .halt_req          (halt_req),
    .wake_req          (wake_req),
    .wdt_enable        (wdt_enable),
    .wdt_timeout       (wdt_timeout),
    .fast_osc_ready    (fast_osc_ready),
    .slow_osc_ready    (slow_osc_ready),
    .slow_osc_tick     (slow_osc_tick),
    .sys_clk_tick      (sys_clk_tick),
    .clk_en            (clk_en),
    .fast_osc_freq_sel (fast_osc_freq_sel),
    .wdt_clear         (wdt_clear)
  );

  always #4 sys_clk = ~sys_clk;

  // slow oscillator stand-in, free running
  always @(posedge sys_clk) begin
    slow_cnt      <= (slow_cnt == SLOW_PER - 1) ? 0 : slow_cnt + 1;
    slow_osc_tick <= (slow_cnt == SLOW_PER - 1);
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task fail_out;
    n_errors++;
    results();
  endtask

  // request held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [7:0] wd);
    int i;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= {24'h0, wd};
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) fail_out();
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h0);
    check(rd, exp);
  endtask

  task waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // gap between the second and third tick seen
  task period(output int q);
    int i;
    int n;
    q = 0;
    n = 0;
    for (i = 0; i < 400 && n < 3; i++) begin
      @(posedge sys_clk);
      q++;
      if (sys_clk_tick === 1'b1) begin
        n++;
        if (n < 3) q = 0;
      end
    end
    if (n < 3) fail_out();
  endtask

  // 0 halt, 1 wake, 2 watchdog timeout; returns one edge after
  task pulse(input int w);
    @(posedge sys_clk);
    {halt_req, wake_req, wdt_timeout} <= 3'b100 >> w;
    @(posedge sys_clk);
    {halt_req, wake_req, wdt_timeout} <= 3'b000;
    @(posedge sys_clk);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    {halt_req, wake_req, wdt_enable, wdt_timeout} = 4'h0;
    fast_osc_ready = 1'b0;
    slow_osc_ready = 1'b1;
    n_errors = 0;
    checks_done = 0;
    for (int i = 0; i < 8; i++) begin
      rows[i].sel  = 3'(i);
      rows[i].freq = 2'(i);
      rows[i].per  = (i == 7) ? SLOW_PER : (1 << i);
      rows[i].fsel = (i % 4 == 3) ? 2'h0 : 2'(i);
    end
    waitc(2);
    reset_n <= 1'b1;
    rdc(scm_pkg::OFF_SYSCLK, 32'h0);
    rdc(scm_pkg::OFF_FASTOSC, 32'h1);
    rdc(scm_pkg::OFF_STATUS, 32'h0);
    fast_osc_ready <= 1'b1;
    foreach (rows[i]) begin
      wr(scm_pkg::OFF_FASTOSC, {4'h0, rows[i].freq, 2'b01});
      wr(scm_pkg::OFF_SYSCLK, {rows[i].sel, 5'h0});
      waitc(150);
      check(fast_osc_freq_sel, rows[i].fsel);
      rdc(scm_pkg::OFF_SYSCLK, {rows[i].sel, 5'h0});
      period(p);
      check(p, rows[i].per);
      rdc(scm_pkg::OFF_STATUS, {rows[i].sel == 3'h7, 5'h0});
    end
    // fast oscillator off in slow mode, then restarted
    fast_osc_ready <= 1'b0;
    wr(scm_pkg::OFF_FASTOSC, 8'h00);
    waitc(4);
    check(clk_en.fast_osc_on, 32'h0);
    wr(scm_pkg::OFF_FASTOSC, 8'h01);
    rdc(scm_pkg::OFF_FASTOSC, 32'h1);
    check(clk_en.fast_osc_on, 32'h1);
    wr(scm_pkg::OFF_SYSCLK, 8'h00);
    waitc(100);
    rdc(scm_pkg::OFF_STATUS, 32'h20);
    fast_osc_ready <= 1'b1;
    waitc(100);
    rdc(scm_pkg::OFF_FASTOSC, 32'h3);
    rdc(scm_pkg::OFF_STATUS, 32'h0);
    // changeover to slow held off until slow oscillator is ready
    slow_osc_ready <= 1'b0;
    wr(scm_pkg::OFF_SYSCLK, 8'he0);
    waitc(100);
    rdc(scm_pkg::OFF_STATUS, 32'h0);
    slow_osc_ready <= 1'b1;
    waitc(100);
    rdc(scm_pkg::OFF_STATUS, 32'h20);
    wr(scm_pkg::OFF_SYSCLK, 8'h00);
    waitc(100);
    wr(scm_pkg::OFF_SYSCLK, 8'h1c);
    rdc(scm_pkg::OFF_SYSCLK, 32'h0);
    avs_byteenable <= 4'he;
    wr(scm_pkg::OFF_SYSCLK, 8'h03);
    avs_byteenable <= 4'hf;
    rdc(scm_pkg::OFF_SYSCLK, 32'h0);
    wr(4'hc, 8'hff);
    rdc(4'hc, 32'h0);
    // every halt variant; last pass is sleep with watchdog on
    for (int k = 0; k < 5; k++) begin
      kk = 2'(k);
      wdt_enable <= (k == 4);
      wr(scm_pkg::OFF_SYSCLK, {6'h0, kk});
      pulse(2);
      rdc(scm_pkg::OFF_STATUS, 32'h2);
      case (kk)
        2'h0: begin e = {3'h0, k == 4}; m = 3'h1; end
        2'h1: begin e = 4'h3; m = 3'h2; end
        2'h3: begin e = 4'h7; m = 3'h3; end
        default: begin e = 4'h5; m = 3'h4; end
      endcase
      pulse(0);
      check(wdt_clear, 32'h1);
      check(32'(clk_en), 32'(e));
      rdc(scm_pkg::OFF_STATUS, {m, 2'b01});
      pulse(1);
      check(clk_en.cpu_run, 32'h1);
      rdc(scm_pkg::OFF_SYSCLK, {30'h0, kk});
      wr(scm_pkg::OFF_STATUS, 8'h03);
      rdc(scm_pkg::OFF_STATUS, 32'h0);
    end
    // second reset in mid-run
    wr(scm_pkg::OFF_SYSCLK, 8'h43);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    waitc(2);
    reset_n <= 1'b1;
    rdc(scm_pkg::OFF_SYSCLK, 32'h0);
    rdc(scm_pkg::OFF_STATUS, 32'h0);
    results();
  end
endmodule // test_scm_clk_ctrl
